// ==== rtl/hpsi_host_port.sv ====
// host port mode select, shared pin mapping and interrupt output
//
// Behaviour
// - select high gives an i2c slave port, select low gives an spi slave.
// - in spi mode the select_or_addr_lo pin is an active low chip select.
// - in i2c mode both shared pins are address straps on the base address.
// - in spi mode serial data is sampled from serial_in_or_addr_hi.
// - in spi mode the data output is driven only while chip select is low and the core drives it, parked off in i2c mode.
// - the interrupt pin pulls low only for enabled causes.
// - causes are pin change, rx error, rx data, tx space and modem flag.
// - reset returns all host port and interrupt logic to its start state.
`timescale 1ns/1ps
module hpsi_host_port (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       port_select_in,
	input  wire logic       select_or_addr_lo_pin_in,
	input  wire logic       serial_in_or_addr_hi_pin_in,
	input  wire logic       spi_sclk_rise_in,
	input  wire logic       core_so_data_in,
	input  wire logic       core_so_drive_in,
	input  wire logic       sda_in,
	input  wire logic       core_sda_low_in,
	input  wire logic [4:0] irq_sources_in,
	input  wire logic [4:0] interrupt_source_enables_in,
	output logic            i2c_mode_out,
	output logic            spi_mode_out,
	output logic            spi_frame_active_out,
	output logic            spi_bit_valid_out,
	output logic            spi_bit_out,
	output logic [6:0]      i2c_slave_addr_out,
	output logic            i2c_sda_in_out,
	output logic            so_out,
	output logic            so_oe_out,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic            irq_n_out,
	output logic            irq_n_oe_out
);
	logic       i2c_sel;
	logic [1:0] strap_reg;
	logic       irq_oe;
	logic [4:0] pending;

	// mode follows the select pin; assumes it stays static
	assign i2c_sel = (port_select_in == hpsi_pkg::SEL_I2C);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			i2c_mode_out <= 1'b0;
			spi_mode_out <= 1'b0;
		end else begin
			i2c_mode_out <= i2c_sel;
			spi_mode_out <= !i2c_sel;
		end
	end

	// active low chip select frames spi
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			spi_frame_active_out <= 1'b0;
		else
			spi_frame_active_out <= !i2c_sel && !select_or_addr_lo_pin_in;
	end

	// data sampled from shared pin on clock rise
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			spi_bit_valid_out <= 1'b0;
			spi_bit_out       <= 1'b0;
		end else begin
			spi_bit_valid_out <= !i2c_sel && !select_or_addr_lo_pin_in
				&& spi_sclk_rise_in;
			if (!i2c_sel && !select_or_addr_lo_pin_in && spi_sclk_rise_in)
				spi_bit_out <= serial_in_or_addr_hi_pin_in;
		end
	end

	// straps tracked only in i2c mode
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			strap_reg <= hpsi_pkg::STRAP_RESET;
		else if (i2c_sel)
			strap_reg <= {serial_in_or_addr_hi_pin_in,
				select_or_addr_lo_pin_in};
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			i2c_slave_addr_out <= hpsi_pkg::BASE_ADDR;
		else
			i2c_slave_addr_out <= hpsi_pkg::BASE_ADDR
				| {5'h00, strap_reg};
	end

	// so driven only in spi frames
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			so_out    <= 1'b0;
			so_oe_out <= 1'b0;
		end else begin
			so_out    <= core_so_data_in;
			so_oe_out <= !i2c_sel && !select_or_addr_lo_pin_in
				&& core_so_drive_in;
		end
	end

	// sda ignored in spi mode since the board grounds it
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			i2c_sda_in_out <= 1'b1;
			sda_out        <= 1'b0;
			sda_oe_out     <= 1'b0;
		end else begin
			i2c_sda_in_out <= i2c_sel ? sda_in : 1'b1;
			sda_out        <= 1'b0;
			sda_oe_out     <= i2c_sel && core_sda_low_in;
		end
	end

	hpsi_irq_gate u_irq (
		.ref_clk_in                  (ref_clk_in),
		.rst_in                      (rst_in),
		.irq_sources_in              (irq_sources_in),
		.interrupt_source_enables_in (interrupt_source_enables_in),
		.irq_oe_out                  (irq_oe),
		.irq_pending_out             (pending)
	);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			irq_n_out    <= 1'b0;
			irq_n_oe_out <= 1'b0;
		end else begin
			irq_n_out    <= 1'b0;
			irq_n_oe_out <= irq_oe;
		end
	end

	a_so_off_i2c: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		$past(port_select_in) |-> !so_oe_out)
		else $error("so driven in i2c mode");
	a_frame_by_cs: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(!port_select_in && !select_or_addr_lo_pin_in)
		|=> spi_frame_active_out)
		else $error("spi frame not opened by chip select");
	a_mode_follow: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		port_select_in |=> (i2c_mode_out && !spi_mode_out))
		else $error("i2c mode not selected");
	a_strap_addr: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(port_select_in && $past(port_select_in)) |=>
		(i2c_slave_addr_out[1:0] == ($past(strap_reg) | 2'h0)))
		else $error("slave address not from straps");
	a_bit_sample: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(!port_select_in && !select_or_addr_lo_pin_in && spi_sclk_rise_in)
		|=> (spi_bit_valid_out
		&& spi_bit_out == $past(serial_in_or_addr_hi_pin_in)))
		else $error("spi bit not sampled");
	a_irq_two_stage: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(|(irq_sources_in & interrupt_source_enables_in))
		|-> ##2 irq_n_oe_out)
		else $error("enabled cause did not pull interrupt low");
	a_reset_idle: assert property (@(posedge ref_clk_in)
		rst_in |=> (!irq_n_oe_out && !so_oe_out && !sda_oe_out))
		else $error("outputs driven after reset");
	a_sda_spi_off: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!port_select_in |=> (!sda_oe_out && i2c_sda_in_out))
		else $error("sda used in spi mode");

	// refused side of each path: a stuck enable would slip past the
	// positive checks above
	a_frame_closed: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(port_select_in || select_or_addr_lo_pin_in)
		|=> !spi_frame_active_out)
		else $error("spi frame open without chip select");
	a_bit_refused: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(port_select_in || select_or_addr_lo_pin_in || !spi_sclk_rise_in)
		|=> !spi_bit_valid_out)
		else $error("spi bit taken outside a frame");
	a_so_cs_high: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		select_or_addr_lo_pin_in |=> !so_oe_out)
		else $error("so driven while chip select is high");
	a_strap_hold: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!port_select_in |=> $stable(strap_reg))
		else $error("straps moved while pins carry spi traffic");

	// pass-through of mode, so and sda, one cycle behind the pins
	a_spi_mode_follow: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!port_select_in |=> (spi_mode_out && !i2c_mode_out))
		else $error("spi mode not selected");
	a_so_drive: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(!port_select_in && !select_or_addr_lo_pin_in && core_so_drive_in)
		|=> (so_oe_out && so_out == $past(core_so_data_in)))
		else $error("so not driven in an spi frame");
	a_sda_forward: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		port_select_in |=> (i2c_sda_in_out == $past(sda_in)
		&& sda_oe_out == $past(core_sda_low_in)))
		else $error("sda not passed through in i2c mode");

	// interrupt path: gate stage then pin stage, skipped at reset release
	a_pending_mask: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!$past(rst_in) |-> (pending == $past(irq_sources_in
		& interrupt_source_enables_in)))
		else $error("pending causes do not match enabled sources");
	a_irq_follow: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!$past(rst_in) |-> (irq_n_oe_out == $past(irq_oe)))
		else $error("interrupt pin does not follow the gated request");

	// reset clears mode and address state, not only the enables
	a_reset_addr: assert property (@(posedge ref_clk_in)
		rst_in |=> (i2c_slave_addr_out == hpsi_pkg::BASE_ADDR
		&& !i2c_mode_out && !spi_mode_out && i2c_sda_in_out))
		else $error("host port state not cleared by reset");
endmodule : hpsi_host_port

// ==== rtl/hpsi_pkg.sv ====
// shared constants for the host port select and interrupt block
package hpsi_pkg;
	localparam int          SRC_COUNT     = 5;
	localparam logic [4:0]  ENABLE_RESET  = 5'h00;
	// interrupt source bit positions
	localparam int          SRC_PIN_CHG   = 0;
	localparam int          SRC_RX_ERR    = 1;
	localparam int          SRC_RX_DATA   = 2;
	localparam int          SRC_TX_SPACE  = 3;
	localparam int          SRC_MODEM     = 4;
	// strap bits placed in the low slave address bits
	localparam logic [6:0]  BASE_ADDR     = 7'h48;
	localparam logic [1:0]  STRAP_RESET   = 2'h0;
	localparam logic        SEL_I2C       = 1'b1;
	localparam logic        SEL_SPI       = 1'b0;
endpackage : hpsi_pkg

// ==== rtl/hpsi_irq_gate.sv ====
// interrupt source gating and open-drain request
`timescale 1ns/1ps
module hpsi_irq_gate (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic [4:0] irq_sources_in,
	input  wire logic [4:0] interrupt_source_enables_in,
	output logic            irq_oe_out,
	output logic [4:0]      irq_pending_out
);
	logic [4:0] pend_next;

	assign pend_next = irq_sources_in & interrupt_source_enables_in;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			irq_oe_out      <= 1'b0;
			irq_pending_out <= hpsi_pkg::ENABLE_RESET;
		end else begin
			irq_oe_out      <= |pend_next;
			irq_pending_out <= pend_next;
		end
	end

	a_irq_enabled_only: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!(|($past(irq_sources_in) & $past(interrupt_source_enables_in)))
		|-> !irq_oe_out)
		else $error("interrupt asserted with no enabled cause");
endmodule : hpsi_irq_gate

// ==== test/hpsi_host_model.sv ====
// host master model driving the shared serial pins
`timescale 1ns/1ps
module hpsi_host_model (
	input  wire logic ref_clk_in,
	input  wire logic port_select_in,
	input  wire logic sda_oe_in,
	output logic      cs_n_out,
	output logic      si_out,
	output logic      sclk_rise_out,
	output logic      sda_out
);
	// grounded in spi mode, pull-up in i2c mode
	assign sda_out = port_select_in ? !sda_oe_in : 1'h0;
	initial begin
		cs_n_out = 1'h1;
		si_out = 1'h0;
		sclk_rise_out = 1'h0;
	end
	task automatic set_pins(input logic lo, input logic hi);
		cs_n_out = lo;
		si_out = hi;
	endtask : set_pins
	// released data line shows the inverse so a stale bit never passes
	task automatic send_bit(input logic b);
		si_out = b;
		sclk_rise_out = 1'h1;
		@(negedge ref_clk_in);
		sclk_rise_out = 1'h0;
		si_out = !b;
	endtask : send_bit
endmodule : hpsi_host_model

// ==== test/hpsi_host_port_test.sv ====
// self-checking bench for the host port select block
`timescale 1ns/1ps
module hpsi_host_port_test;
	typedef struct packed {
		logic [1:0] strap;
		logic [4:0] src;
		logic [4:0] en;
		logic [6:0] addr;
		logic       irq;
	} hpsi_row_type;
	logic       ref_clk_in = 1'h0, rst_in = 1'h1, port_select_in = 1'h1;
	logic       core_so_data_in = 1'h0, core_so_drive_in = 1'h0;
	logic       core_sda_low_in = 1'h0;
	logic [4:0] irq_sources_in = 5'h00, interrupt_source_enables_in = 5'h00;
	logic       select_or_addr_lo_pin_in, serial_in_or_addr_hi_pin_in;
	logic       spi_sclk_rise_in, sda_in, i2c_mode_out, spi_mode_out;
	logic       spi_frame_active_out, spi_bit_valid_out, spi_bit_out;
	logic       i2c_sda_in_out, so_out, so_oe_out, sda_out, sda_oe_out;
	logic       irq_n_out, irq_n_oe_out;
	logic [6:0] i2c_slave_addr_out;
	int         n_mismatch = 0, cmp_count = 0;
	hpsi_row_type rows [7] = '{'{2'h0, 5'h01, 5'h01, 7'h48, 1'h1},
		'{2'h1, 5'h02, 5'h00, 7'h49, 1'h0}, '{2'h2, 5'h04, 5'h04, 7'h4a, 1'h1},
		'{2'h3, 5'h08, 5'h17, 7'h4b, 1'h0}, '{2'h3, 5'h10, 5'h10, 7'h4b, 1'h1},
		'{2'h0, 5'h1f, 5'h08, 7'h48, 1'h1}, '{2'h1, 5'h02, 5'h02, 7'h49, 1'h1}};
	hpsi_host_port hpsi_host_port_i (.ref_clk_in, .rst_in, .port_select_in,
		.select_or_addr_lo_pin_in, .serial_in_or_addr_hi_pin_in,
		.spi_sclk_rise_in, .core_so_data_in, .core_so_drive_in, .sda_in,
		.core_sda_low_in, .irq_sources_in, .interrupt_source_enables_in,
		.i2c_mode_out, .spi_mode_out, .spi_frame_active_out,
		.spi_bit_valid_out, .spi_bit_out, .i2c_slave_addr_out,
		.i2c_sda_in_out, .so_out, .so_oe_out, .sda_out, .sda_oe_out,
		.irq_n_out, .irq_n_oe_out);
	hpsi_host_model hpsi_host_model_i (.ref_clk_in, .port_select_in,
		.sda_oe_in(sda_oe_out), .cs_n_out(select_or_addr_lo_pin_in),
		.si_out(serial_in_or_addr_hi_pin_in),
		.sclk_rise_out(spi_sclk_rise_in), .sda_out(sda_in));
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : step
	always #2.5 ref_clk_in = !ref_clk_in;
	// whole run is under 100 cycles, so this margin only cuts a hang
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		step(4);
		rst_in = 1'h0;
		foreach (rows[i]) begin
			hpsi_host_model_i.set_pins(rows[i].strap[0], rows[i].strap[1]);
			irq_sources_in = rows[i].src;
			interrupt_source_enables_in = rows[i].en;
			step(3);
			chk(i2c_slave_addr_out, rows[i].addr);
			chk(irq_n_oe_out, rows[i].irq);
			chk(i2c_mode_out, 1'h1);
			chk(so_oe_out, 1'h0);
		end
		core_sda_low_in = 1'h1;
		step(2);
		chk(i2c_sda_in_out, 1'h0);
		core_sda_low_in = 1'h0;
		// select moves only between transfers, never mid-frame
		port_select_in = 1'h0;
		hpsi_host_model_i.set_pins(1'h1, 1'h0);
		core_so_drive_in = 1'h1;
		core_so_data_in = 1'h1;
		step(2);
		chk({i2c_mode_out, spi_mode_out}, 7'h01);
		chk(so_oe_out, 1'h0);
		hpsi_host_model_i.send_bit(1'h1);
		chk({spi_frame_active_out, spi_bit_valid_out}, 7'h00);
		step(1);
		hpsi_host_model_i.set_pins(1'h0, 1'h0);
		step(2);
		chk(spi_frame_active_out, 1'h1);
		chk({so_oe_out, so_out, i2c_sda_in_out, sda_oe_out}, 7'h0e);
		hpsi_host_model_i.send_bit(1'h1);
		chk({spi_bit_valid_out, spi_bit_out}, 7'h03);
		step(1);
		chk(spi_bit_valid_out, 1'h0);
		hpsi_host_model_i.send_bit(1'h0);
		chk({spi_bit_valid_out, spi_bit_out}, 7'h02);
		irq_sources_in = 5'h10;
		interrupt_source_enables_in = 5'h1f;
		step(3);
		chk(irq_n_oe_out, 1'h1);
		rst_in = 1'h1;
		step(2);
		chk({irq_n_oe_out, spi_mode_out, so_oe_out}, 7'h00);
		chk(i2c_slave_addr_out, hpsi_pkg::BASE_ADDR);
		chk({irq_n_out, sda_out}, 7'h00);
		rst_in = 1'h0;
		step(2);
		chk({irq_n_oe_out, spi_mode_out}, 7'h03);
		end_sim();
	end
endmodule : hpsi_host_port_test
